/* File: design/caccm_defines.vh */
// constants of the counter array capture/compare channels
`ifndef CACCM_DEFINES_VH
`define CACCM_DEFINES_VH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define CACCM_NCH          6

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define CACCM_PWM_CFG_OFS  8'h00
`define CACCM_FLAGS_OFS    8'h04
`define CACCM_MODE_REGION  3'h1
`define CACCM_CMP_REGION   2'h1

// ----------------------------------------------------------------------------
// channel_mode_reg fields
// ----------------------------------------------------------------------------
`define CACCM_M_WIDE       7
`define CACCM_M_ECOM       6
`define CACCM_M_CAPP       5
`define CACCM_M_CAPN       4
`define CACCM_M_MAT        3
`define CACCM_M_TOG        2
`define CACCM_M_PWM        1
`define CACCM_M_IRQ        0

// ----------------------------------------------------------------------------
// pwm_config_reg fields
// ----------------------------------------------------------------------------
`define CACCM_P_RELOAD_ACCESS_SELECT      7
`define CACCM_P_INTERMEDIATE_OVERFLOW_FLAG       6
`define CACCM_P_INTERMEDIATE_OVERFLOW_IRQ_ENABLE       5
`define CACCM_P_CL_MSB     1
`define CACCM_P_CL_LSB     0

// ----------------------------------------------------------------------------
// reset values and cycle length masks
// ----------------------------------------------------------------------------
`define CACCM_RST_BYTE     8'h00
`define CACCM_RST_WORD     16'h0000
`define CACCM_MASK8        16'h00FF
`define CACCM_MASK9        16'h01FF
`define CACCM_MASK10       16'h03FF
`define CACCM_MASK11       16'h07FF
`define CACCM_MASK16       16'hFFFF

`endif

/* File: design/caccm_top.v */
// six capture/compare channels on one shared 16-bit counter, Avalon-MM slave
`timescale 1ns/10ps
`include "caccm_defines.vh"

// How it works
// - mode bits 5/4 pick capture edge
// - qualifying edge copies counter, sets flag
// - pin level must hold two clocks
// - flags cleared only by software zero write
// - mode bit 0 gates channel interrupt
// - timer mode compares full 16-bit word
// - timer and toggle matches set flag
// - low write clears, high write sets enable
// - high-speed output inverts pin on match
// - enable clear: no toggle, PWM low
// - frequency mode toggles, adds high offset
// - zero offset means 256 clock half-period
// - frequency mode flags on full match
// - cycle length field selects 8-11 bits
// - one cycle length shared by channels
// - wide select bit gives 16-bit PWM
// - config bit 7 steers reload access
// - config bit 5 enables overflow interrupt
// - 8-bit PWM high on match, low overflow
// - 8-bit PWM reloads low from high
// - 8-bit PWM match flag and overflow
// - 9-11 bit PWM with auto-reload
// - 16-bit PWM match high, overflow low
// - overflow flag at selected counter bit
module caccm_top (
  // clock and reset
  input  wire        SYS_CLK_I,
  input  wire        RESETN_I,
  // avalon-mm slave
  input  wire [7:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  output wire [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  // shared counter
  input  wire [15:0] COUNT_I,
  input  wire        COUNT_TICK_I,
  // channel pins
  input  wire [5:0]  CHAN_PIN_I,
  output wire [5:0]  CHAN_PIN_O,
  output wire [5:0]  CHAN_PIN_OE_O,
  // interrupt requests
  output wire [5:0]  CHAN_IRQ_O,
  output wire        OVF_IRQ_O
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  reg  [1:0]  rst_sync;
  wire        rst_n = rst_sync[1];

  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // --------------------------------------------------------------------------
  // bus slave: one wait cycle, write lands when waitrequest is low
  // --------------------------------------------------------------------------
  reg         wreq;
  reg  [31:0] rdata;
  reg  [31:0] rd_val;
  wire        acc_w = AVS_WRITE_I & ~wreq;
  wire        rd_take = AVS_READ_I & wreq;
  wire [7:0]  addr = AVS_ADDRESS_I;
  wire        aligned = (addr[1:0] == 2'b00);
  wire [2:0]  idx_m = addr[4:2];
  wire [2:0]  idx_c = addr[5:3];
  wire        mode_sel = aligned & (addr[7:5] == `CACCM_MODE_REGION) & (idx_m < 3'd6);
  wire        cmp_sel  = aligned & (addr[7:6] == `CACCM_CMP_REGION) & (idx_c < 3'd6);
  wire        cmp_hi   = addr[2];
  wire        cfg_wr   = acc_w & (addr == `CACCM_PWM_CFG_OFS);
  wire        flags_wr = acc_w & (addr == `CACCM_FLAGS_OFS);

  assign AVS_WAITREQUEST_O = wreq;
  assign AVS_READDATA_O    = rdata;

  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wreq  <= 1'b1;
      rdata <= 32'h00000000;
    end else begin
      wreq <= ~((AVS_READ_I | AVS_WRITE_I) & wreq);
      if (rd_take) begin
        rdata <= rd_val;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pwm_config_reg and intermediate overflow
  // --------------------------------------------------------------------------
  reg         reload_access_select;
  reg         intermediate_overflow_irq_enable;
  reg  [1:0]  cyc_len;
  reg         intermediate_overflow_flag;
  reg         ovf_irq;
  reg  [15:0] len_mask;

  // one mask for every 8-11 bit channel, so lengths cannot differ
  always @* begin
    case (cyc_len)
      2'b00:   len_mask = `CACCM_MASK8;
      2'b01:   len_mask = `CACCM_MASK9;
      2'b10:   len_mask = `CACCM_MASK10;
      2'b11:   len_mask = `CACCM_MASK11;
      default: len_mask = `CACCM_MASK8;
    endcase
  end

  // tick marks the first cycle of a new count, so zero low bits means a wrap
  wire ovf_sel = COUNT_TICK_I & ((COUNT_I & len_mask) == 16'h0000);
  wire ovf16   = COUNT_TICK_I & (COUNT_I == 16'h0000);

  assign OVF_IRQ_O = ovf_irq;

  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      reload_access_select   <= 1'b0;
      intermediate_overflow_irq_enable    <= 1'b0;
      cyc_len <= 2'b00;
      intermediate_overflow_flag    <= 1'b0;
      ovf_irq <= 1'b0;
    end else begin
      if (cfg_wr) begin
        reload_access_select   <= AVS_WRITEDATA_I[`CACCM_P_RELOAD_ACCESS_SELECT];
        intermediate_overflow_irq_enable    <= AVS_WRITEDATA_I[`CACCM_P_INTERMEDIATE_OVERFLOW_IRQ_ENABLE];
        cyc_len <= AVS_WRITEDATA_I[`CACCM_P_CL_MSB:`CACCM_P_CL_LSB];
        if (!AVS_WRITEDATA_I[`CACCM_P_INTERMEDIATE_OVERFLOW_FLAG]) begin
          intermediate_overflow_flag <= 1'b0;
        end
      end
      // set after the clear so a coinciding overflow is kept
      if (ovf_sel) begin
        intermediate_overflow_flag <= 1'b1;
      end
      ovf_irq <= intermediate_overflow_flag & intermediate_overflow_irq_enable;
    end
  end

  // --------------------------------------------------------------------------
  // pin synchroniser and two-clock stability filter
  // --------------------------------------------------------------------------
  reg  [5:0]  pin_s1;
  reg  [5:0]  pin_s2;
  reg  [5:0]  pin_s3;
  reg  [5:0]  pin_flt;
  wire [5:0]  stable = ~(pin_s2 ^ pin_s3);
  wire [5:0]  rise   = stable & pin_s2 & ~pin_flt;
  wire [5:0]  fall   = stable & ~pin_s2 & pin_flt;

  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1  <= 6'h00;
      pin_s2  <= 6'h00;
      pin_s3  <= 6'h00;
      pin_flt <= 6'h00;
    end else begin
      pin_s1  <= CHAN_PIN_I;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      // a glitch shorter than two samples never reaches the filtered level
      pin_flt <= (stable & pin_s2) | (~stable & pin_flt);
    end
  end

  // --------------------------------------------------------------------------
  // channels
  // --------------------------------------------------------------------------
  wire [47:0] mode_all;
  wire [95:0] cmp_all;
  wire [95:0] rld_all;
  wire [5:0]  flag_all;
  wire [5:0]  out_all;
  wire [5:0]  oe_all;
  wire [5:0]  irq_all;

  genvar n;
  generate
    for (n = 0; n < `CACCM_NCH; n = n + 1) begin : g_ch
      localparam [2:0] CH = n;
      reg  [7:0]  mode;
      reg  [15:0] cmp;
      reg  [15:0] rld;
      reg         flag;
      reg         out;
      reg         oe;
      reg         irq;
      wire        wr_mode = acc_w & mode_sel & (idx_m == CH);
      wire        wr_lo   = acc_w & cmp_sel & (idx_c == CH) & ~cmp_hi;
      wire        wr_hi   = acc_w & cmp_sel & (idx_c == CH) & cmp_hi;
      wire        ecom    = mode[`CACCM_M_ECOM];
      wire        mat     = mode[`CACCM_M_MAT];
      wire        tog     = mode[`CACCM_M_TOG];
      wire        pwm     = mode[`CACCM_M_PWM];
      wire        wide    = mode[`CACCM_M_WIDE];
      wire        is_cap  = ~mat & ~tog & ~pwm;
      wire        edge_ok = (mode[`CACCM_M_CAPP] & rise[n]) | (mode[`CACCM_M_CAPN] & fall[n]);
      wire        is_tmr  = ecom & mat & ~tog & ~pwm;
      wire        is_hso  = ecom & mat & tog & ~pwm;
      wire        is_frq  = ecom & tog & pwm;
      wire        is_pwm_select = pwm & ~tog & ~wide;
      wire        is_pw16 = pwm & ~tog & wide;
      wire        match16 = COUNT_TICK_I & (COUNT_I == cmp);
      wire        match_l = COUNT_TICK_I & (COUNT_I[7:0] == cmp[7:0]);
      wire        match_n = COUNT_TICK_I & (((COUNT_I ^ cmp) & len_mask) == 16'h0000);
      wire        clr     = flags_wr & ~AVS_WRITEDATA_I[n];

      always @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          mode <= `CACCM_RST_BYTE;
          cmp  <= `CACCM_RST_WORD;
          rld  <= `CACCM_RST_WORD;
          flag <= 1'b0;
          out  <= 1'b0;
          oe   <= 1'b0;
          irq  <= 1'b0;
        end else begin
          oe <= tog | pwm;
          // only a software zero write clears; later sets override it
          if (clr) begin
            flag <= 1'b0;
          end
          if (is_cap && edge_ok) begin
            cmp  <= COUNT_I;
            flag <= 1'b1;
          end
          if ((is_tmr || is_hso) && match16) begin
            flag <= 1'b1;
          end
          if (is_hso && match16) begin
            out <= ~out;
          end
          if (is_frq && match_l) begin
            out <= ~out;
            // 8-bit wrap: a zero offset lands on the same value 256 clocks on
            cmp[7:0] <= cmp[7:0] + cmp[15:8];
          end
          if (is_frq && mat && match16) begin
            flag <= 1'b1;
          end
          if (is_pwm_select) begin
            if (!ecom) begin
              out <= 1'b0;
            end else begin
              if (ovf_sel) begin
                out <= 1'b0;
                if (cyc_len == 2'b00) begin
                  cmp[7:0] <= cmp[15:8];
                end else begin
                  cmp <= rld;
                end
              end
              // match after overflow: a zero compare gives full duty
              if (match_n) begin
                out <= 1'b1;
                if (mat) begin
                  flag <= 1'b1;
                end
              end
            end
          end
          if (is_pw16) begin
            if (!ecom) begin
              out <= 1'b0;
            end else begin
              if (ovf16) begin
                out <= 1'b0;
              end
              if (match16) begin
                out <= 1'b1;
                if (mat) begin
                  flag <= 1'b1;
                end
              end
            end
          end
          // mode, compare and reload writes come last and win over a same-cycle hardware update
          if (wr_mode) begin
            mode <= AVS_WRITEDATA_I[7:0];
          end
          if (wr_lo) begin
            if (reload_access_select) begin
              rld[7:0] <= AVS_WRITEDATA_I[7:0];
            end else begin
              cmp[7:0] <= AVS_WRITEDATA_I[7:0];
            end
            mode[`CACCM_M_ECOM] <= 1'b0;
          end
          if (wr_hi) begin
            if (reload_access_select) begin
              rld[15:8] <= AVS_WRITEDATA_I[7:0];
            end else begin
              cmp[15:8] <= AVS_WRITEDATA_I[7:0];
            end
            mode[`CACCM_M_ECOM] <= 1'b1;
          end
          irq <= flag & mode[`CACCM_M_IRQ];
        end
      end

      assign mode_all[8*n +: 8]  = mode;
      assign cmp_all[16*n +: 16] = cmp;
      assign rld_all[16*n +: 16] = rld;
      assign flag_all[n]         = flag;
      assign out_all[n]          = out;
      assign oe_all[n]           = oe;
      assign irq_all[n]          = irq;
    end
  endgenerate

  assign CHAN_PIN_O    = out_all;
  assign CHAN_PIN_OE_O = oe_all;
  assign CHAN_IRQ_O    = irq_all;

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  wire [15:0] cmp_sel_w = cmp_all[{idx_c, 4'h0} +: 16];
  wire [15:0] rld_sel_w = rld_all[{idx_c, 4'h0} +: 16];
  wire [15:0] word_w    = reload_access_select ? rld_sel_w : cmp_sel_w;

  always @* begin
    rd_val = 32'h00000000;
    if (addr == `CACCM_PWM_CFG_OFS) begin
      rd_val = {24'h000000, reload_access_select, intermediate_overflow_flag, intermediate_overflow_irq_enable, 3'b000, cyc_len};
    end else if (addr == `CACCM_FLAGS_OFS) begin
      rd_val = {26'h0000000, flag_all};
    end else if (mode_sel) begin
      rd_val = {24'h000000, mode_all[{idx_m, 3'b000} +: 8]};
    end else if (cmp_sel) begin
      rd_val = {24'h000000, (cmp_hi ? word_w[15:8] : word_w[7:0])};
    end
  end

endmodule // caccm_top

/* File: testbench/caccm_monitor.sv */
// port checker of the capture/compare channels
`timescale 1ns/10ps
module caccm_monitor (
  // clock and reset
  input wire        SYS_CLK_I,
  input wire        RESETN_I,
  // register bus
  input wire [7:0]  AVS_ADDRESS_I,
  input wire        AVS_READ_I,
  input wire        AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [31:0] AVS_READDATA_O,
  input wire        AVS_WAITREQUEST_O,
  // counter, pins, irqs
  input wire [15:0] COUNT_I,
  input wire        COUNT_TICK_I,
  input wire [5:0]  CHAN_PIN_I,
  input wire [5:0]  CHAN_PIN_O,
  input wire [5:0]  CHAN_PIN_OE_O,
  input wire [5:0]  CHAN_IRQ_O,
  input wire        OVF_IRQ_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // write that lands at this edge
  wire wl = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  // ----------------------------------------
  // bus timing
  // ----------------------------------------
  property p_one_wait; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer late");
  property p_pulse; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
  a_pulse: assert property (p_pulse) else $error("waitrequest low too long");
  property p_fell_cause; $fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I); endproperty
  a_fell_cause: assert property (p_fell_cause) else $error("answer without request");
  property p_unmapped; AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[7] |-> AVS_READDATA_O == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ----------------------------------------
  // channel outputs
  // ----------------------------------------
  // only a software write may drop an interrupt
  property p_irq_fall; |($past(CHAN_IRQ_O) & ~CHAN_IRQ_O) |-> $past(wl, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by hardware");
  property p_pin_paced; CHAN_PIN_O != $past(CHAN_PIN_O) |-> $past(COUNT_TICK_I) || $past(wl) || $past(wl, 2); endproperty
  a_pin_paced: assert property (p_pin_paced) else $error("pin moved without tick");
  property p_ovf_rise; $rose(OVF_IRQ_O) |-> $past(COUNT_TICK_I, 2) || $past(wl, 2); endproperty
  a_ovf_rise: assert property (p_ovf_rise) else $error("overflow irq without cause");
  property p_oe; CHAN_PIN_OE_O != $past(CHAN_PIN_OE_O) |-> $past(wl) || $past(wl, 2); endproperty
  a_oe: assert property (p_oe) else $error("enable moved without write");
endmodule // caccm_monitor

bind caccm_top caccm_monitor mon_u (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .COUNT_I(COUNT_I),
  .COUNT_TICK_I(COUNT_TICK_I), .CHAN_PIN_I(CHAN_PIN_I), .CHAN_PIN_O(CHAN_PIN_O),
  .CHAN_PIN_OE_O(CHAN_PIN_OE_O), .CHAN_IRQ_O(CHAN_IRQ_O), .OVF_IRQ_O(OVF_IRQ_O));

/* File: testbench/caccm_top_tb.sv */
// self-checking bench of the capture/compare channels
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module caccm_top_tb;
  reg          clk = 0;
  reg          rst_n = 0;
  reg  [7:0]   adr = 0;
  reg          rd = 0;
  reg          wr = 0;
  reg  [31:0]  wd = 0;
  reg  [15:0]  cnt = 0;
  reg          tk = 0;
  reg  [5:0]   pin = 0;
  wire [31:0]  rdat;
  wire         wreq;
  wire [5:0]   po;
  wire [5:0]   poe;
  wire [5:0]   irq;
  wire         oirq;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [31:0] expq[$];
  logic [31:0] seed = 32'd81779;
  logic [15:0] cw;
  always #4 clk = ~clk;
  caccm_top dut_u (.SYS_CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .COUNT_I(cnt), .COUNT_TICK_I(tk),
    .CHAN_PIN_I(pin), .CHAN_PIN_O(po), .CHAN_PIN_OE_O(poe), .CHAN_IRQ_O(irq), .OVF_IRQ_O(oirq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin error_cnt++; give_verdict(); end
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d); bus(1, a, d); endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e); expq.push_back({24'h0, e}); bus(0, a, 8'h00); endtask
  // one counter step; outputs settle by the edge this returns on
  task automatic tick(input logic [15:0] v);
    cnt <= v;
    tk <= 1;
    @(posedge clk);
    tk <= 0;
    @(posedge clk);
  endtask
  task automatic outs(input logic [5:0] p, input logic [5:0] i, input logic o);
    #1;
    `CHK(po, p)
    `CHK(irq, i)
    `CHK(oirq, o)
    @(posedge clk);
  endtask
  // read results are compared when they appear on the bus
  // pop once: the compare macro names its expected value twice
  always @(posedge clk) begin : rd_chk
    logic [31:0] exp_rd;
    if (rd && wreq === 1'b0) begin
      exp_rd = expq.pop_front();
      `CHK(rdat, exp_rd)
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (5) @(posedge clk);
    rd8(8'h00, 8'h00); rd8(8'h04, 8'h00); rd8(8'h20, 8'h00); rd8(8'h80, 8'h00);
    // high-speed output on channel 0 with a random word
    cw = xs();
    wr8(8'h20, 8'h4D);
    wr8(8'h40, cw[7:0]); rd8(8'h20, 8'h0D);
    wr8(8'h44, cw[15:8]); rd8(8'h20, 8'h4D);
    tick(cw ^ 16'h0001); outs(6'h00, 6'h00, 0);
    tick(cw); tick(cw ^ 16'h0001); outs(6'h01, 6'h01, 0);
    rd8(8'h04, 8'h01);
    wr8(8'h04, 8'h00); rd8(8'h04, 8'h00);
    wr8(8'h40, cw[7:0]); tick(cw); outs(6'h01, 6'h00, 0);
    // capture on channel 1: glitch, then held level, then falling only
    cnt <= 16'hA5C3;
    wr8(8'h24, 8'h21);
    pin[1] <= 1; @(posedge clk); pin[1] <= 0; repeat (6) @(posedge clk);
    rd8(8'h04, 8'h00);
    pin[1] <= 1; repeat (6) @(posedge clk);
    rd8(8'h04, 8'h02); rd8(8'h48, 8'hC3); rd8(8'h4C, 8'hA5);
    outs(6'h01, 6'h02, 0);
    wr8(8'h24, 8'h10); wr8(8'h04, 8'h00);
    pin[1] <= 0; repeat (6) @(posedge clk);
    rd8(8'h04, 8'h02);
    wr8(8'h04, 8'h00);
    // 8-bit pwm on channel 2
    wr8(8'h28, 8'h42); wr8(8'h50, 8'h80); wr8(8'h54, 8'h40);
    tick(16'h0080); outs(6'h05, 6'h00, 0);
    tick(16'h0100); outs(6'h01, 6'h00, 0);
    rd8(8'h50, 8'h40); rd8(8'h00, 8'h40);
    wr8(8'h00, 8'h60); outs(6'h01, 6'h00, 1);
    // 9-bit pwm, reload through the steered bytes
    wr8(8'h00, 8'hE1); wr8(8'h50, 8'h00); wr8(8'h54, 8'h01);
    wr8(8'h00, 8'h21);
    tick(16'h0200); rd8(8'h54, 8'h01);
    tick(16'h0300); outs(6'h05, 6'h00, 1);
    tick(16'h0400); outs(6'h01, 6'h00, 1);
    // frequency output on channel 3, zero offset wraps whole byte
    wr8(8'h58, 8'h10); wr8(8'h5C, 8'h00); wr8(8'h2C, 8'h46);
    tick(16'h0010); outs(6'h09, 6'h00, 1);
    rd8(8'h58, 8'h10);
    // match flag on in frequency mode: only the full word sets it
    wr8(8'h2C, 8'h4E);
    tick(16'h0110); outs(6'h01, 6'h00, 1);
    rd8(8'h04, 8'h00);
    tick(16'h0010); outs(6'h09, 6'h00, 1);
    rd8(8'h04, 8'h08); wr8(8'h04, 8'h00);
    // software timer on channel 4, high byte must match too
    wr8(8'h60, 8'h34); wr8(8'h64, 8'h12); wr8(8'h30, 8'h49);
    tick(16'h1334); outs(6'h09, 6'h00, 1);
    tick(16'h1234); outs(6'h09, 6'h10, 1);
    rd8(8'h04, 8'h10); wr8(8'h04, 8'h00);
    // 16-bit pwm on channel 5 ignores the 9-bit cycle length
    wr8(8'h68, 8'h00); wr8(8'h6C, 8'h80); wr8(8'h34, 8'hCA);
    tick(16'h8000); outs(6'h29, 6'h00, 1);
    tick(16'h0200); outs(6'h29, 6'h00, 1);
    tick(16'h0000); outs(6'h09, 6'h00, 1);
    rd8(8'h04, 8'h20); wr8(8'h04, 8'h00);
    // 8-bit pwm with match flag on channel 2
    wr8(8'h00, 8'h60); wr8(8'h50, 8'h20); wr8(8'h54, 8'h20); wr8(8'h28, 8'h4A);
    tick(16'h0020); outs(6'h0D, 6'h00, 1);
    rd8(8'h04, 8'h04);
    `CHK(poe, 6'h2D)
    give_verdict();
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // caccm_top_tb
